// ==== fpu_flash_protect_unlock.sv ====
// module: flash protect and unlock sequencer, top level
//
// How it works
// (RULE1) reset always leaves the controller locked
// (RULE2) software stores target page before unlocking
// (RULE3) unlock is command 73 then 8c
// (RULE4) mismatched second page write relocks
// (RULE5) matching second page write activates page
// (RULE6) 95 erases active page unless sector protected
// (RULE7) unexpected command value relocks controller
// (RULE8) user mass erase refused, debug allowed
// (RULE9) active page accepts repeated byte writes
// (RULE10) any command write relocks active page
// (RULE11) option bit zero blocks all user programming
// (RULE12) up to eight sectors, never below page
// (RULE13) protection bits sticky, user cannot clear
// (RULE14) protection clears on every reset
// (RULE15) 5e routes page address to protection
// (RULE16) 63 honoured only as third command
// (RULE17) locked controller ignores program and erase
// (RULE18) command register write-only, resets zero
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
module fpu_flash_protect_unlock
  import fpu_pkg::*;
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      resetn_i,
  input  wire logic [FPU_ADDR_W-1:0]     reg_addr_i,
  input  wire logic [FPU_DATA_W-1:0]     reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic      [FPU_DATA_W-1:0]     reg_rdata_o,
  input  wire logic                      flash_write_protect_option_i,
  input  wire logic                      dbg_mass_erase_i,
  input  wire logic                      prog_req_i,
  input  wire logic [FPU_ARRAY_W-1:0]    prog_addr_i,
  input  wire logic [FPU_DATA_W-1:0]     prog_data_i,
  output logic                           flash_wr_o,
  output logic      [FPU_ARRAY_W-1:0]    flash_addr_o,
  output logic      [FPU_DATA_W-1:0]     flash_data_o,
  output logic                           page_erase_o,
  output logic      [FPU_PAGE_NUM_W-1:0] erase_page_o,
  output logic                           mass_erase_o,
  output logic                           page_active_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // shared decode helpers

  // one address compare shared by the command, page and protect write decodes; the read port decodes with its own case
  function automatic logic fpu_addr_hit(
    input logic [FPU_ADDR_W-1:0] addr,
    input logic [FPU_ADDR_W-1:0] ofs
  );
    return (addr == ofs);
  endfunction : fpu_addr_hit

  // page number in the upper bits of an array byte address
  function automatic logic [FPU_PAGE_NUM_W-1:0] fpu_page_of(
    input logic [FPU_ARRAY_W-1:0] addr
  );
    return addr[FPU_ARRAY_W-1:FPU_PAGE_OFS_W];
  endfunction : fpu_page_of

  // status word: state, protect-register select, option bit
  function automatic logic [FPU_DATA_W-1:0] fpu_status_word(
    input fpu_state_t state,
    input logic       spsel,
    input logic       wpo
  );
    logic [FPU_DATA_W-1:0] s;
    s                          = '0;
    s[FPU_STAT_STATE_LSB +: 2] = state;
    s[FPU_STAT_SPSEL_BIT]      = spsel;
    s[FPU_STAT_WPO_BIT]        = wpo;
    return s;
  endfunction : fpu_status_word

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  fpu_state_t                state_d;
  fpu_state_t                state_q;
  logic                      sp_sel_d;
  logic                      sp_sel_q;
  logic [FPU_PAGE_NUM_W-1:0] page_d;
  logic [FPU_PAGE_NUM_W-1:0] page_q;
  logic [FPU_DATA_W-1:0]     cmd_d;
  logic [FPU_DATA_W-1:0]     cmd_q;
  logic                      perase_d;
  logic                      perase_q;
  logic                      merase_d;
  logic                      merase_q;
  logic [FPU_PAGE_NUM_W-1:0] epage_d;
  logic [FPU_PAGE_NUM_W-1:0] epage_q;
  logic [FPU_DATA_W-1:0]     rdata_d;
  logic [FPU_DATA_W-1:0]     rdata_q;
  logic                      active_d;
  logic                      active_q;

  logic                      cmd_wr;
  logic                      page_wr;
  logic                      prot_wr;
  logic                      page_prot;
  logic                      user_ok;
  logic                      prog_allow;
  logic [FPU_SECT_N-1:0]     prot;
  logic [FPU_PAGE_NUM_W-1:0] wr_page;
  logic                      page_hit;

  assign cmd_wr  = reg_wr_i && fpu_addr_hit(reg_addr_i, FPU_OFS_CMD);
  assign page_wr = reg_wr_i && fpu_addr_hit(reg_addr_i, FPU_OFS_PAGE) && !sp_sel_q;
  assign prot_wr = reg_wr_i && fpu_addr_hit(reg_addr_i, FPU_OFS_PAGE) && sp_sel_q; // (RULE15)
  assign wr_page = FPU_PAGE_NUM_W'(reg_wdata_i);

  // user program/erase needs the option bit set
  assign user_ok = flash_write_protect_option_i; // (RULE11)

  // a byte write must fall inside the active, unprotected page
  assign page_hit   = (fpu_page_of(prog_addr_i) == page_q); // (RULE9)
  assign prog_allow = (state_q == FPU_ACTIVE) && user_ok && !page_prot && page_hit; // (RULE9)

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    state_d  = state_q;
    sp_sel_d = sp_sel_q;
    page_d   = page_q;
    cmd_d    = cmd_q;
    if (cmd_wr) begin
      cmd_d    = reg_wdata_i;
      sp_sel_d = 1'b0;
      state_d  = FPU_LOCKED; // (RULE7)
      case (state_q)
        FPU_LOCKED: begin
          if (reg_wdata_i == FPU_CMD_UNLOCK1) begin
            state_d = FPU_UNLK1; // (RULE3)
          end
        end
        FPU_UNLK1: begin
          if (reg_wdata_i == FPU_CMD_UNLOCK2) begin
            state_d = FPU_UNLK2; // (RULE3)
          end
        end
        FPU_UNLK2: begin
          // 63 is the right third command, but user code may never mass erase
          if (reg_wdata_i == FPU_CMD_MERASE) begin
            state_d = FPU_LOCKED; // (RULE8) (RULE16)
          end
        end
        FPU_ACTIVE: begin
          state_d = FPU_LOCKED; // (RULE10)
        end
        default: begin
          state_d = FPU_LOCKED;
        end
      endcase
      if (reg_wdata_i == FPU_CMD_SPSEL) begin
        sp_sel_d = 1'b1; // (RULE15)
      end
    end else if (page_wr) begin
      case (state_q)
        FPU_LOCKED: begin
          page_d = wr_page; // (RULE2)
        end
        FPU_UNLK1: begin
          state_d = FPU_UNLK1;
        end
        FPU_UNLK2: begin
          if (wr_page == page_q) begin
            state_d = FPU_ACTIVE; // (RULE5)
          end else begin
            state_d = FPU_LOCKED; // (RULE4)
          end
        end
        FPU_ACTIVE: begin
          state_d = FPU_ACTIVE;
        end
        default: begin
          state_d = FPU_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q  <= FPU_LOCKED; // (RULE1)
      sp_sel_q <= 1'b0;
      page_q   <= FPU_PAGE_RST;
      cmd_q    <= FPU_CMD_RST; // (RULE18)
    end else begin
      state_q  <= state_d;
      sp_sel_q <= sp_sel_d;
      page_q   <= page_d;
      cmd_q    <= cmd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // active-page flag, registered so the port comes straight from a flip-flop

  always_comb begin
    active_d = (state_d == FPU_ACTIVE); // (RULE5) (RULE10)
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_q <= 1'b0; // (RULE1)
    end else begin
      active_q <= active_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // erase starts; page erase a one-cycle pulse, mass erase as long as the debug request

  always_comb begin
    perase_d = 1'b0;
    epage_d  = epage_q;
    // debug port mass erase ignores the option bit and the lock
    merase_d = dbg_mass_erase_i; // (RULE8) (RULE11)
    if (cmd_wr && (state_q == FPU_ACTIVE) && (reg_wdata_i == FPU_CMD_PERASE) &&
        user_ok && !page_prot) begin
      perase_d = 1'b1; // (RULE6)
      epage_d  = page_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      perase_q <= 1'b0;
      merase_q <= 1'b0;
      epage_q  <= FPU_PAGE_RST;
    end else begin
      perase_q <= perase_d;
      merase_q <= merase_d;
      epage_q  <= epage_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port

  always_comb begin
    rdata_d = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        FPU_OFS_CMD: begin
          rdata_d = '0; // (RULE18)
        end
        FPU_OFS_PAGE: begin
          rdata_d = sp_sel_q ? prot : FPU_DATA_W'(page_q); // (RULE15)
        end
        FPU_OFS_STAT: begin
          rdata_d = fpu_status_word(state_q, sp_sel_q, flash_write_protect_option_i);
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protection and program path

  fpu_sector_guard u_guard (
    .clk_sys_i   (clk_sys_i),
    .resetn_i    (resetn_i),
    .wr_i        (prot_wr),
    .wdata_i     (reg_wdata_i),
    .page_i      (page_q),
    .prot_o      (prot),
    .page_prot_o (page_prot)
  );

  fpu_prog_gate u_gate (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .req_i     (prog_req_i),
    .addr_i    (prog_addr_i),
    .data_i    (prog_data_i),
    .allow_i   (prog_allow),
    .wr_o      (flash_wr_o),
    .addr_o    (flash_addr_o),
    .data_o    (flash_data_o)
  );

  assign reg_rdata_o   = rdata_q;
  assign page_erase_o  = perase_q;
  assign erase_page_o  = epage_q;
  assign mass_erase_o  = merase_q;
  assign page_active_o = active_q;

endmodule : fpu_flash_protect_unlock

// ==== fpu_flash_protect_unlock_assertions.sv ====
// checker: port-level assertions for the flash protect and unlock sequencer
`timescale 1ns/100ps
module fpu_chk
  import fpu_pkg::*;
(
  input wire logic                      clk_sys_i,
  input wire logic                      resetn_i,
  input wire logic [FPU_ADDR_W-1:0]     reg_addr_i,
  input wire logic [FPU_DATA_W-1:0]     reg_wdata_i,
  input wire logic                      reg_wr_i,
  input wire logic                      reg_rd_i,
  input wire logic [FPU_DATA_W-1:0]     reg_rdata_o,
  input wire logic                      flash_write_protect_option_i,
  input wire logic                      dbg_mass_erase_i,
  input wire logic                      prog_req_i,
  input wire logic [FPU_ARRAY_W-1:0]    prog_addr_i,
  input wire logic [FPU_DATA_W-1:0]     prog_data_i,
  input wire logic                      flash_wr_o,
  input wire logic [FPU_ARRAY_W-1:0]    flash_addr_o,
  input wire logic [FPU_DATA_W-1:0]     flash_data_o,
  input wire logic                      page_erase_o,
  input wire logic [FPU_PAGE_NUM_W-1:0] erase_page_o,
  input wire logic                      mass_erase_o,
  input wire logic                      page_active_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic cmd_wr;
  assign cmd_wr = reg_wr_i && (reg_addr_i == FPU_OFS_CMD);
  ////////////////////////////////////////////////////////////////////////////////
  chk_cmd_reads_zero: assert property (reg_rd_i && reg_addr_i == FPU_OFS_CMD |=>
    reg_rdata_o == 8'h00) else $error("command register read not zero");
  chk_wr_gated: assert property (flash_wr_o |-> $past(page_active_o && prog_req_i
    && flash_write_protect_option_i)) else $error("byte write without active page");
  chk_wr_payload: assert property (flash_wr_o |-> flash_addr_o == $past(prog_addr_i)
    && flash_data_o == $past(prog_data_i)) else $error("byte write payload wrong");
  chk_erase_gated: assert property (page_erase_o |-> $past(page_active_o && cmd_wr
    && reg_wdata_i == FPU_CMD_PERASE && flash_write_protect_option_i))
    else $error("page erase without cause");
  chk_cmd_relocks: assert property (page_active_o && cmd_wr |=> !page_active_o)
    else $error("active page kept after command write");
  chk_mass_dbg: assert property (dbg_mass_erase_i |=> mass_erase_o)
    else $error("debug mass erase not started");
  chk_mass_user: assert property (mass_erase_o |-> $past(dbg_mass_erase_i))
    else $error("mass erase without debug request");
  chk_active_cause: assert property ($rose(page_active_o) |-> $past(reg_wr_i
    && reg_addr_i == FPU_OFS_PAGE)) else $error("page active without page write");
  chk_erase_single: assert property (page_erase_o |=> !page_erase_o[*2])
    else $error("page erase pulse too long");
  cov_write: cover property (flash_wr_o);
  cov_erase: cover property (page_erase_o);
  cov_mass: cover property (mass_erase_o);
endmodule : fpu_chk

bind fpu_flash_protect_unlock fpu_chk u_fpu_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .dbg_mass_erase_i(dbg_mass_erase_i),
  .flash_write_protect_option_i(flash_write_protect_option_i), .prog_req_i(prog_req_i),
  .prog_addr_i(prog_addr_i), .prog_data_i(prog_data_i), .flash_wr_o(flash_wr_o),
  .flash_addr_o(flash_addr_o), .flash_data_o(flash_data_o), .page_erase_o(page_erase_o),
  .erase_page_o(erase_page_o), .mass_erase_o(mass_erase_o), .page_active_o(page_active_o));

// ==== fpu_pkg.sv ====
// package: constants, command codes and states of the flash protect/unlock sequencer
package fpu_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned FPU_ADDR_W     = 12;
  localparam int unsigned FPU_DATA_W     = 8;
  localparam int unsigned FPU_ARRAY_W    = 12;
  localparam int unsigned FPU_PAGE_OFS_W = 9;
  localparam int unsigned FPU_PAGE_NUM_W = FPU_ARRAY_W - FPU_PAGE_OFS_W;
  localparam int unsigned FPU_SECT_N     = 8;
  localparam int unsigned FPU_SECT_W     = 3;
  localparam int unsigned FPU_SECT_SHIFT =
    (FPU_PAGE_NUM_W > FPU_SECT_W) ? (FPU_PAGE_NUM_W - FPU_SECT_W) : 0;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [FPU_ADDR_W-1:0] FPU_OFS_CMD  = 12'hff8;
  localparam logic [FPU_ADDR_W-1:0] FPU_OFS_PAGE = 12'hff9;
  localparam logic [FPU_ADDR_W-1:0] FPU_OFS_STAT = 12'hffa;

  // status register fields
  localparam int unsigned FPU_STAT_STATE_LSB = 0;
  localparam int unsigned FPU_STAT_SPSEL_BIT = 2;
  localparam int unsigned FPU_STAT_WPO_BIT   = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [FPU_DATA_W-1:0] FPU_CMD_UNLOCK1 = 8'h73;
  localparam logic [FPU_DATA_W-1:0] FPU_CMD_UNLOCK2 = 8'h8c;
  localparam logic [FPU_DATA_W-1:0] FPU_CMD_PERASE  = 8'h95;
  localparam logic [FPU_DATA_W-1:0] FPU_CMD_MERASE  = 8'h63;
  localparam logic [FPU_DATA_W-1:0] FPU_CMD_SPSEL   = 8'h5e;

  // reset values
  localparam logic [FPU_DATA_W-1:0]     FPU_CMD_RST  = 8'h00;
  localparam logic [FPU_SECT_N-1:0]     FPU_PROT_RST = 8'h00;
  localparam logic [FPU_PAGE_NUM_W-1:0] FPU_PAGE_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [1:0] {
    FPU_LOCKED = 2'b00,
    FPU_UNLK1  = 2'b01,
    FPU_UNLK2  = 2'b10,
    FPU_ACTIVE = 2'b11
  } fpu_state_t;

  // sector that holds a page
  function automatic logic [FPU_SECT_W-1:0] fpu_sect_of(input logic [FPU_PAGE_NUM_W-1:0] page);
    logic [FPU_PAGE_NUM_W-1:0] s;
    s = page >> FPU_SECT_SHIFT;
    return FPU_SECT_W'(s);
  endfunction : fpu_sect_of

endpackage : fpu_pkg

// ==== fpu_prog_gate.sv ====
// module: byte-program gate between cpu writes and the flash array
`timescale 1ns/100ps
module fpu_prog_gate
  import fpu_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   resetn_i,
  input  wire logic                   req_i,
  input  wire logic [FPU_ARRAY_W-1:0] addr_i,
  input  wire logic [FPU_DATA_W-1:0]  data_i,
  input  wire logic                   allow_i,
  output logic                        wr_o,
  output logic      [FPU_ARRAY_W-1:0] addr_o,
  output logic      [FPU_DATA_W-1:0]  data_o
);

  logic                   wr_d;
  logic                   wr_q;
  logic [FPU_ARRAY_W-1:0] addr_d;
  logic [FPU_ARRAY_W-1:0] addr_q;
  logic [FPU_DATA_W-1:0]  data_d;
  logic [FPU_DATA_W-1:0]  data_q;

  // address and data only move on an accepted write, so a refused one leaves no trace
  always_comb begin
    wr_d   = req_i & allow_i; // (RULE17)
    addr_d = addr_q;
    data_d = data_q;
    if (wr_d) begin
      addr_d = addr_i;
      data_d = data_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_q   <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
    end else begin
      wr_q   <= wr_d;
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end

  assign wr_o   = wr_q;
  assign addr_o = addr_q;
  assign data_o = data_q;

endmodule : fpu_prog_gate

// ==== fpu_sector_guard.sv ====
// module: sticky sector-protect register and per-page protection lookup
`timescale 1ns/100ps
module fpu_sector_guard
  import fpu_pkg::*;
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      resetn_i,
  input  wire logic                      wr_i,
  input  wire logic [FPU_DATA_W-1:0]     wdata_i,
  input  wire logic [FPU_PAGE_NUM_W-1:0] page_i,
  output logic      [FPU_SECT_N-1:0]     prot_o,
  output logic                           page_prot_o
);

  logic [FPU_SECT_N-1:0] prot_d;
  logic [FPU_SECT_N-1:0] prot_q;

  always_comb begin
    prot_d = prot_q;
    if (wr_i) begin
      prot_d = prot_q | wdata_i; // (RULE13)
    end
  end

  // only a reset can unprotect a sector
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prot_q <= FPU_PROT_RST; // (RULE14)
    end else begin
      prot_q <= prot_d;
    end
  end

  assign prot_o      = prot_q;
  assign page_prot_o = prot_q[fpu_sect_of(page_i)]; // (RULE12)

endmodule : fpu_sector_guard

// ==== tb.sv ====
// testbench: register-port sequences for the flash protect and unlock sequencer
`timescale 1ns/100ps
module tb;
  import fpu_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        opt_i = 1'b1;
  logic        dbg_i = 1'b0;
  logic        prog_req_i = 1'b0;
  logic [11:0] prog_addr_i = 12'h000;
  logic [7:0]  prog_data_i = 8'h00;
  logic [7:0]  reg_rdata_o, flash_data_o;
  logic [11:0] flash_addr_o;
  logic [2:0]  erase_page_o;
  logic        flash_wr_o, page_erase_o, mass_erase_o, page_active_o;
  int          bad_count = 0;
  int          compares = 0;
  int          n_wr = 0, n_pe = 0, n_me = 0;

  fpu_flash_protect_unlock u_fpu_flash_protect_unlock (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .flash_write_protect_option_i(opt_i), .dbg_mass_erase_i(dbg_i),
    .prog_req_i(prog_req_i), .prog_addr_i(prog_addr_i), .prog_data_i(prog_data_i),
    .flash_wr_o(flash_wr_o), .flash_addr_o(flash_addr_o), .flash_data_o(flash_data_o),
    .page_erase_o(page_erase_o), .erase_page_o(erase_page_o),
    .mass_erase_o(mass_erase_o), .page_active_o(page_active_o));

  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // pulses counted at the edge after they rise, so one-cycle outputs are never missed
  always @(posedge clk_sys_i) begin
    if (flash_wr_o === 1'b1) n_wr++;
    if (page_erase_o === 1'b1) n_pe++;
    if (mass_erase_o === 1'b1) n_me++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic w(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : w
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask : rc
  task automatic p(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    prog_req_i <= 1'b1;
    prog_addr_i <= a;
    prog_data_i <= d;
    @(posedge clk_sys_i);
    prog_req_i <= 1'b0;
  endtask : p
  task automatic st();
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : st
  task automatic unl(input logic [7:0] pg, input logic [7:0] pg2);
    w(FPU_OFS_PAGE, pg);
    w(FPU_OFS_CMD, 8'h73);
    w(FPU_OFS_CMD, 8'h8c);
    w(FPU_OFS_PAGE, pg2);
    #1;
  endtask : unl
  task automatic rst();
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    #1;
  endtask : rst
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic final_report();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    bad_count++;
    final_report();
  end
  initial begin
    rst();
    chk(page_active_o, 1'b0);
    rc(FPU_OFS_CMD, 8'h00);
    rc(FPU_OFS_STAT, 8'h08);
    p(12'h400, 8'h11);
    st();
    chk(n_wr, 0);
    done("reset");
    unl(8'h02, 8'h02);
    chk(page_active_o, 1'b1);
    p(12'h400, 8'ha5);
    p(12'h5ff, 8'h3c);
    p(12'h200, 8'h77);
    st();
    chk(n_wr, 2);
    chk({flash_addr_o, flash_data_o[3:0]}, {12'h5ff, 4'hc});
    w(FPU_OFS_CMD, FPU_CMD_PERASE);
    st();
    chk({n_pe[3:0], erase_page_o, page_active_o}, {4'h1, 3'h2, 1'b0});
    done("unlock");
    unl(8'h02, 8'h03);
    chk(page_active_o, 1'b0);
    w(FPU_OFS_PAGE, 8'h01);
    w(FPU_OFS_CMD, 8'h73);
    w(FPU_OFS_CMD, 8'h55);
    rc(FPU_OFS_STAT, 8'h08);
    unl(8'h01, 8'h01);
    w(FPU_OFS_CMD, FPU_CMD_MERASE);
    st();
    chk(n_me, 0);
    w(FPU_OFS_CMD, 8'h73);
    w(FPU_OFS_CMD, 8'h8c);
    w(FPU_OFS_CMD, FPU_CMD_MERASE);
    st();
    chk(n_me, 0);
    rc(FPU_OFS_STAT, 8'h08);
    @(posedge clk_sys_i) dbg_i <= 1'b1;
    @(posedge clk_sys_i) dbg_i <= 1'b0;
    st();
    chk(n_me, 1);
    done("relock");
    @(posedge clk_sys_i) opt_i <= 1'b0;
    unl(8'h01, 8'h01);
    p(12'h200, 8'h42);
    w(FPU_OFS_CMD, FPU_CMD_PERASE);
    @(posedge clk_sys_i) dbg_i <= 1'b1;
    @(posedge clk_sys_i) dbg_i <= 1'b0;
    st();
    chk({n_wr[3:0], n_pe[3:0], n_me[3:0]}, 12'h212);
    @(posedge clk_sys_i) opt_i <= 1'b1;
    done("option");
    w(FPU_OFS_CMD, FPU_CMD_SPSEL);
    w(FPU_OFS_PAGE, 8'h08);
    rc(FPU_OFS_PAGE, 8'h08);
    w(FPU_OFS_PAGE, 8'h01);
    w(FPU_OFS_PAGE, 8'h00);
    rc(FPU_OFS_PAGE, 8'h09);
    w(FPU_OFS_CMD, 8'h00);
    unl(8'h03, 8'h03);
    p(12'h600, 8'h99);
    w(FPU_OFS_CMD, FPU_CMD_PERASE);
    st();
    chk({n_wr[3:0], n_pe[3:0]}, 8'h21);
    done("sector");
    unl(8'h02, 8'h02);
    rst();
    chk(page_active_o, 1'b0);
    w(FPU_OFS_CMD, FPU_CMD_SPSEL);
    rc(FPU_OFS_PAGE, 8'h00);
    done("second reset");
    final_report();
  end
endmodule : tb
